// *** logic/pwmfim_cfg.svh ***
`ifndef PWMFIM_CFG_SVH
`define PWMFIM_CFG_SVH
// Function
// - ten mode codes, zero idle, others reserved
// - mode 1 jumps opposite dead-time, holds
// - mode 1 own phases only, own output
// - mode 2 runs opposite cycle, then waits
// - mode 3 repeats opposite cycle while active
// - modes 2/3 act in own phases only
// - mode 4 blanks both, counter untouched
// - mode 5 alternates dead-times while active
// - mode 6 jumps to dead-time, then holds
// - mode 7 stops until software restart
// - mode 8 edge in on-time jumps opposite
// - mode 9 edge blanks rest of on-time
// - mode 10 blanks while active, to on-end
// - mode 2 resumes at own dead-time
// - event acts two to three cycles later

// ****************************************
// fault response mode codes
// ****************************************
`define PWMFIM_MODE_NONE       4'h0
`define PWMFIM_MODE_JUMP_WAIT  4'h1
`define PWMFIM_MODE_EXEC_WAIT  4'h2
`define PWMFIM_MODE_EXEC_LOOP  4'h3
`define PWMFIM_MODE_OFF_ALL    4'h4
`define PWMFIM_MODE_DEAD_LOOP  4'h5
`define PWMFIM_MODE_JUMP_HOLD  4'h6
`define PWMFIM_MODE_SW_WAIT    4'h7
`define PWMFIM_MODE_EDGE_JUMP  4'h8
`define PWMFIM_MODE_EDGE_BLANK 4'h9
`define PWMFIM_MODE_LVL_BLANK  4'hA

// ****************************************
// hold masks, one bit per input
// ****************************************
`define PWMFIM_MASK_NONE 2'h0
`define PWMFIM_MASK_A    2'h1
`define PWMFIM_MASK_B    2'h2
`define PWMFIM_MASK_BOTH 2'h3
`endif

// *** logic/pwmfim_pkg.sv ***
package pwmfim_pkg;
	// ****************************************
	// counter sequence phases
	// ****************************************
	typedef enum logic [1:0] {
		PH_DTA,
		PH_OTA,
		PH_DTB,
		PH_OTB
	} pwmfim_phase_type;
endpackage

// *** logic/pwmfim_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwmfim_cfg.svh"

module pwmfim_top
	import pwmfim_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// event inputs from routing network
	input  wire logic       i_fault_a,
	input  wire logic       i_fault_b,
	// fault_response_select per input
	input  wire logic [3:0] i_fault_response_select_a,
	input  wire logic [3:0] i_fault_response_select_b,
	// timer sequencing
	input  wire logic       i_phase_end,
	input  wire logic       i_restart,
	// outputs
	output logic            o_pwm_out_a,
	output logic            o_pwm_out_b,
	output logic [1:0]      o_phase,
	output logic            o_cnt_run,
	output logic            o_cnt_clear
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic pwmfim_phase_type next_ph(input pwmfim_phase_type p);
		unique case (p)
			PH_DTA: next_ph = PH_OTA;
			PH_OTA: next_ph = PH_DTB;
			PH_DTB: next_ph = PH_OTB;
			PH_OTB: next_ph = PH_DTA;
		endcase
	endfunction

	function automatic pwmfim_phase_type own_dt(input logic x);
		own_dt = x ? PH_DTB : PH_DTA;
	endfunction

	function automatic pwmfim_phase_type own_ot(input logic x);
		own_ot = x ? PH_OTB : PH_OTA;
	endfunction

	function automatic pwmfim_phase_type opp_dt(input logic x);
		opp_dt = x ? PH_DTA : PH_DTB;
	endfunction

	// dead-time of the half opposite to phase p
	function automatic pwmfim_phase_type opp_of(input pwmfim_phase_type p);
		opp_of = (p == PH_DTA || p == PH_OTA) ? PH_DTB : PH_DTA;
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [1:0]       sync1_q;
	logic [1:0]       sync2_q;
	logic [1:0]       flt_prev_q;
	logic [1:0]       flt;
	logic [1:0]       rise;
	logic [3:0]       mode [2];

	// two stages plus the output flop give the 2-3 cycle latency
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			flt_prev_q <= 2'h0;
		end else begin
			sync1_q <= {i_fault_b, i_fault_a};
			sync2_q <= sync1_q;
			flt_prev_q <= sync2_q;
		end
	end

	// edge detect on the settled stage only
	assign flt = sync2_q;
	assign rise = sync2_q & ~flt_prev_q;
	assign mode[0] = i_fault_response_select_a;
	assign mode[1] = i_fault_response_select_b;

	// ****************************************
	// response state
	// ****************************************
	pwmfim_phase_type phase_q, ph_d;
	logic             hold_q, hold_d;
	logic [1:0]       hmask_q, hmask_d;
	logic [1:0]       pend_q, pend_d;
	logic [1:0]       rep_q, rep_d;
	logic [1:0]       blk_q, blk_d;
	logic             stop_q, stop_d;
	logic             clr_d;
	logic [1:0]       kill_d;
	logic             m7_flt;
	logic             in_own;

	// one pass per input; input b wins a conflicting jump
	always_comb begin
		ph_d = phase_q;
		hold_d = hold_q;
		hmask_d = hmask_q;
		pend_d = pend_q;
		rep_d = rep_q;
		blk_d = blk_q;
		stop_d = stop_q;
		clr_d = 1'b0;
		kill_d = 2'h0;
		m7_flt = 1'b0;
		in_own = 1'b0;
		// counter sequence runs only when not held or stopped
		if (!hold_q && !stop_q && i_phase_end) begin
			ph_d = next_ph(phase_q);
		end
		// release a hold once the watched inputs are low
		if (hold_q && (flt & hmask_q) == `PWMFIM_MASK_NONE) begin
			hold_d = 1'b0;
			hmask_d = `PWMFIM_MASK_NONE;
			clr_d = 1'b1;
		end
		for (int x = 0; x < 2; x++) begin
			in_own = (phase_q == own_dt(x[0])) || (phase_q == own_ot(x[0]));
			// blank lasts to the end of the own on-time
			blk_d[x] = blk_q[x] && (phase_q == own_ot(x[0]));
			unique case (mode[x])
				`PWMFIM_MODE_JUMP_WAIT: begin
					// own phases only, own output only
					if (flt[x] && in_own && !hold_q) begin
						ph_d = opp_dt(x[0]);
						hold_d = 1'b1;
						hmask_d = x[0] ? `PWMFIM_MASK_B : `PWMFIM_MASK_A;
						clr_d = 1'b1;
					end
					if (flt[x] && in_own) begin
						kill_d[x] = 1'b1;
					end
				end
				`PWMFIM_MODE_EXEC_WAIT: begin
					// no new jump while parked in own dead-time after the return
					if (flt[x] && in_own && !pend_q[x] && !hold_q) begin
						ph_d = opp_dt(x[0]);
						pend_d[x] = 1'b1;
						kill_d[x] = 1'b1;
						clr_d = 1'b1;
					end
					// opposite cycle done: back to own dead-time
					if (pend_q[x] && phase_q == own_ot(!x[0]) && i_phase_end) begin
						ph_d = own_dt(x[0]);
						pend_d[x] = 1'b0;
						if (flt[x]) begin
							hold_d = 1'b1;
							hmask_d = x[0] ? `PWMFIM_MASK_B : `PWMFIM_MASK_A;
						end
					end
				end
				`PWMFIM_MODE_EXEC_LOOP: begin
					if (flt[x] && in_own) begin
						ph_d = opp_dt(x[0]);
						rep_d[x] = 1'b1;
						kill_d[x] = 1'b1;
						clr_d = 1'b1;
					end
					// at end of opposite on-time repeat or fall back to normal
					if (rep_q[x] && phase_q == own_ot(!x[0]) && i_phase_end) begin
						if (flt[x]) begin
							ph_d = opp_dt(x[0]);
						end else begin
							rep_d[x] = 1'b0;
						end
					end
				end
				`PWMFIM_MODE_OFF_ALL: begin
					if (flt[x]) begin
						kill_d = `PWMFIM_MASK_BOTH;
					end
				end
				`PWMFIM_MODE_DEAD_LOOP: begin
					if (flt[x]) begin
						kill_d = `PWMFIM_MASK_BOTH;
						if (phase_q == PH_OTA || phase_q == PH_OTB) begin
							ph_d = opp_of(phase_q);
							clr_d = 1'b1;
						end else if (i_phase_end && !hold_q && !stop_q) begin
							ph_d = opp_of(phase_q);
						end
					end
				end
				`PWMFIM_MODE_JUMP_HOLD: begin
					if (flt[x]) begin
						kill_d = `PWMFIM_MASK_BOTH;
					end
					// park in the next dead-time until every input is low
					if (flt[x] && !hold_q && !stop_q &&
						(phase_q == PH_OTA || phase_q == PH_OTB || i_phase_end)) begin
						ph_d = opp_of(phase_q);
						hold_d = 1'b1;
						hmask_d = `PWMFIM_MASK_BOTH;
						clr_d = 1'b1;
					end
				end
				`PWMFIM_MODE_SW_WAIT: begin
					if (flt[x]) begin
						stop_d = 1'b1;
						kill_d = `PWMFIM_MASK_BOTH;
						m7_flt = 1'b1;
					end
				end
				`PWMFIM_MODE_EDGE_JUMP: begin
					if (rise[x] && phase_q == own_ot(x[0])) begin
						ph_d = opp_dt(x[0]);
						clr_d = 1'b1;
					end
				end
				`PWMFIM_MODE_EDGE_BLANK: begin
					if (rise[x] && phase_q == own_ot(x[0])) begin
						blk_d[x] = 1'b1;
					end
				end
				`PWMFIM_MODE_LVL_BLANK: begin
					if (flt[x]) begin
						blk_d[x] = 1'b1;
					end
				end
				// no action, and reserved codes likewise
				default: begin
				end
			endcase
		end
		// restart command: stays stopped if a mode 7 fault is still high
		if (stop_q && i_restart && !m7_flt) begin
			stop_d = 1'b0;
			ph_d = PH_DTA;
			clr_d = 1'b1;
		end
	end

	// phase and wait state
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			phase_q <= PH_DTA;
			hold_q <= 1'b0;
			hmask_q <= `PWMFIM_MASK_NONE;
			stop_q <= 1'b0;
		end else begin
			phase_q <= ph_d;
			hold_q <= hold_d;
			hmask_q <= hmask_d;
			stop_q <= stop_d;
		end
	end

	// per-input sequencing flags
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_q <= 2'h0;
			rep_q <= 2'h0;
			blk_q <= 2'h0;
		end else begin
			pend_q <= pend_d;
			rep_q <= rep_d;
			blk_q <= blk_d;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	// built from next state so the outputs track the phase they show
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pwm_out_a <= 1'b0;
			o_pwm_out_b <= 1'b0;
			o_phase <= 2'h0;
			o_cnt_run <= 1'b0;
			o_cnt_clear <= 1'b0;
		end else begin
			o_pwm_out_a <= ph_d == PH_OTA && !kill_d[0] && !blk_d[0] && !stop_d;
			o_pwm_out_b <= ph_d == PH_OTB && !kill_d[1] && !blk_d[1] && !stop_d;
			o_phase <= ph_d;
			o_cnt_run <= !hold_d && !stop_d;
			o_cnt_clear <= clr_d;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	latency_off_all_a: assert property (
		(i_fault_a && i_fault_response_select_a == `PWMFIM_MODE_OFF_ALL) [*3]
		|=> !o_pwm_out_a && !o_pwm_out_b)
		else $error("mode 4 did not blank outputs in time");

	jump_wait_a: assert property (
		mode[0] == `PWMFIM_MODE_JUMP_WAIT && mode[1] == `PWMFIM_MODE_NONE &&
		flt[0] && !hold_q && !stop_q && (phase_q == PH_DTA || phase_q == PH_OTA)
		|=> phase_q == PH_DTB && hold_q && !o_cnt_run && o_cnt_clear)
		else $error("mode 1 did not jump and hold");

	hold_release_a: assert property (
		hold_q && hmask_q == `PWMFIM_MASK_A && !flt[0] && !stop_q
		|=> !hold_q && o_cnt_clear && o_cnt_run)
		else $error("hold not released");

	own_phase_only_a: assert property (
		mode[0] == `PWMFIM_MODE_EXEC_WAIT && mode[1] == `PWMFIM_MODE_NONE &&
		flt[0] && !pend_q[0] && !rep_q[0] && !hold_q && !stop_q &&
		phase_q == PH_DTB && !i_phase_end
		|=> $stable(phase_q))
		else $error("mode 2 acted outside own phases");

	exec_return_a: assert property (
		pend_q[0] && mode[0] == `PWMFIM_MODE_EXEC_WAIT &&
		mode[1] == `PWMFIM_MODE_NONE && phase_q == PH_OTB && i_phase_end &&
		!hold_q && !stop_q
		|=> phase_q == PH_DTA && !pend_q[0] && (hold_q == $past(flt[0])))
		else $error("mode 2 did not resume at own dead-time");

	sw_stop_a: assert property (
		stop_q && !i_restart |=> stop_q && !o_cnt_run && !o_pwm_out_a)
		else $error("stop left without restart");

	sw_restart_a: assert property (
		stop_q && i_restart && !m7_flt |=> !stop_q && phase_q == PH_DTA)
		else $error("restart did not resume at dead-time a");

	edge_jump_a: assert property (
		mode[0] == `PWMFIM_MODE_EDGE_JUMP && mode[1] == `PWMFIM_MODE_NONE &&
		rise[0] && phase_q == PH_OTA && !stop_q
		|=> phase_q == PH_DTB && !o_pwm_out_a)
		else $error("mode 8 edge did not jump");

	edge_blank_a: assert property (
		mode[0] == `PWMFIM_MODE_EDGE_BLANK && rise[0] && phase_q == PH_OTA
		|=> !o_pwm_out_a)
		else $error("mode 9 edge did not blank");

	level_blank_a: assert property (
		mode[0] == `PWMFIM_MODE_LVL_BLANK && flt[0] |=> !o_pwm_out_a)
		else $error("mode 10 level did not blank");

	reserved_idle_a: assert property (
		mode[0] > `PWMFIM_MODE_LVL_BLANK && mode[1] == `PWMFIM_MODE_NONE &&
		!hold_q && !stop_q |=> o_cnt_run && !o_cnt_clear)
		else $error("reserved mode changed the sequence");

	sw_stop_c: cover property (stop_q && i_restart);
	dead_loop_c: cover property (mode[0] == `PWMFIM_MODE_DEAD_LOOP && flt[0] &&
		phase_q == PH_DTB && i_phase_end);
	exec_wait_c: cover property (pend_q[0] && hold_q);
	edge_blank_c: cover property (blk_q[1] && phase_q == PH_OTB);

endmodule
`default_nettype wire

// *** verif/pwmfim_phase_src.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// compare logic stand-in: ends each phase
// ****************************************
module pwmfim_phase_src (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// counter handshake from the block
	input  wire logic       i_cnt_run,
	input  wire logic       i_cnt_clear,
	// phase length in counter cycles
	input  wire logic [4:0] i_len,
	// phase end pulse to the block
	output logic            o_phase_end
);
	logic [4:0] cnt_q;

	// counts on the falling edge so the pulse is settled at sampling
	always_ff @(negedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q <= 5'h00;
			o_phase_end <= 1'b0;
		end else begin
			o_phase_end <= 1'b0;
			if (i_cnt_clear) begin
				cnt_q <= 5'h00; // forced jump restarts the phase count
			end else if (i_cnt_run) begin
				if (cnt_q >= i_len - 5'h01) begin
					cnt_q <= 5'h00;
					o_phase_end <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 5'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/test_pwm_fault_input_modes.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_pwm_fault_input_modes;
	import pwmfim_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic        i_clk, i_reset_n, i_fault_a, i_fault_b, i_phase_end, i_restart;
	logic [3:0]  sel_a, sel_b;
	logic        o_pwm_out_a, o_pwm_out_b, o_cnt_run, o_cnt_clear;
	logic [1:0]  o_phase;
	logic [4:0]  len;
	logic [31:0] rnd;
	logic        seen_clr;
	int          miscompares, n_tests, it;

	pwmfim_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fault_a(i_fault_a),
		.i_fault_b(i_fault_b), .i_fault_response_select_a(sel_a),
		.i_fault_response_select_b(sel_b), .i_phase_end(i_phase_end),
		.i_restart(i_restart), .o_pwm_out_a(o_pwm_out_a), .o_pwm_out_b(o_pwm_out_b),
		.o_phase(o_phase), .o_cnt_run(o_cnt_run), .o_cnt_clear(o_cnt_clear));

	pwmfim_phase_src src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cnt_run(o_cnt_run),
		.i_cnt_clear(o_cnt_clear), .i_len(len), .o_phase_end(i_phase_end));

	always #4 i_clk = ~i_clk;

	// ****************************************
	// expectation helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// fault-free outputs {b,a} for a phase
	function automatic logic [1:0] exp_out(input logic [1:0] p);
		return {p == 2'd3, p == 2'd1};
	endfunction
	function automatic logic [1:0] opp_dt(input logic [1:0] p);
		return (p < 2'd2) ? 2'd2 : 2'd0;
	endfunction

	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// clear is a one-cycle pulse, so it is caught while ticking
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge i_clk);
			seen_clr = seen_clr | (o_cnt_clear === 1'b1);
		end
	endtask
	task automatic wait_phase(input logic [1:0] p);
		int k;
		for (k = 0; k < 200 && o_phase !== p; k++) @(negedge i_clk);
		chk(o_phase, p);
	endtask
	task automatic idle();
		i_fault_a = 0;
		i_fault_b = 0;
		sel_a = 4'h0;
		sel_b = 4'h0;
		tick(6);
	endtask
	task automatic restart_pulse();
		i_restart = 1;
		tick(1);
		i_restart = 0;
	endtask
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// watchdog sized well above four passes of the sequence
	initial begin
		#400000;
		miscompares++;
		tally_and_finish();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		i_clk = 0; i_reset_n = 0; i_fault_a = 0; i_fault_b = 0; i_restart = 0;
		sel_a = 4'h0; sel_b = 4'h0; len = 5'h0C; rnd = 32'h6177156B; seen_clr = 0;
		tick(2);
		chk({o_pwm_out_b, o_pwm_out_a, o_phase}, 4'h0); // reset values
		i_reset_n = 1;
		tick(2);
		chk(o_cnt_run, 1'b1);
		// only the modes valid in every waveform mode are not singled out
		for (it = 0; it < 4; it++) begin
			rnd = lfsr(rnd);
			len = 5'h0C + rnd[2:0];
			// idle or reserved codes with both faults high
			sel_a = (rnd[7:4] > 4'hA) ? rnd[7:4] : 4'h0;
			sel_b = (rnd[11:8] > 4'hA) ? rnd[11:8] : 4'h0;
			i_fault_a = 1; i_fault_b = 1;
			wait_phase(2'd0); wait_phase(2'd1); tick(3);
			chk({o_cnt_run, o_pwm_out_b, o_pwm_out_a}, {1'b1, exp_out(2'd1)});
			wait_phase(2'd3); tick(3);
			chk({o_cnt_run, o_pwm_out_b, o_pwm_out_a}, {1'b1, exp_out(2'd3)});
			idle();
			// mode 8: edge in on-time A, timing of the override too
			sel_a = 4'h8; wait_phase(2'd1); i_fault_a = 1; seen_clr = 0;
			tick(2); chk(o_phase, 2'd1);
			tick(2); chk({o_phase, o_pwm_out_a, seen_clr}, {opp_dt(2'd1), 2'b01});
			idle();
			// mode 4 on input B blanks both, counter goes on
			sel_b = 4'h4; wait_phase(2'd1); i_fault_b = 1; tick(4);
			chk({o_pwm_out_b, o_pwm_out_a}, 2'b00);
			wait_phase(2'd3); chk({o_cnt_run, o_pwm_out_b, o_pwm_out_a}, 3'b100);
			i_fault_b = 0; tick(4);
			chk({o_pwm_out_b, o_pwm_out_a}, exp_out(2'd3));
			idle();
			// mode 1 on A: ignored in on-time B, then jump and hold
			sel_a = 4'h1; wait_phase(2'd2); wait_phase(2'd3); i_fault_a = 1; tick(4);
			chk({o_phase, o_cnt_run}, {2'd3, 1'b1});
			i_fault_a = 0; wait_phase(2'd1); i_fault_a = 1; tick(4);
			chk({o_phase, o_cnt_run, o_pwm_out_a}, {opp_dt(2'd1), 2'b00});
			tick(20); chk({o_phase, o_cnt_run}, {2'd2, 1'b0});
			i_fault_a = 0; tick(4); chk({o_phase, o_cnt_run}, {2'd2, 1'b1});
			idle();
			// mode 2 on A: opposite half runs, then waits in own dead-time
			sel_a = 4'h2; wait_phase(2'd1); i_fault_a = 1; tick(4);
			chk({o_phase, o_cnt_run, o_pwm_out_a}, {2'd2, 2'b10});
			wait_phase(2'd0); tick(4); chk({o_phase, o_cnt_run}, {2'd0, 1'b0});
			i_fault_a = 0; tick(4); chk({o_phase, o_cnt_run}, {2'd0, 1'b1});
			idle();
			// mode 7: stops until restart, refused while fault high
			sel_a = 4'h7; wait_phase(2'd2); i_fault_a = 1; tick(4);
			chk({o_cnt_run, o_pwm_out_b, o_pwm_out_a}, 3'b000);
			tick(20); chk(o_cnt_run, 1'b0);
			restart_pulse(); tick(6); chk(o_cnt_run, 1'b0);
			i_fault_a = 0; tick(3); seen_clr = 0; restart_pulse(); tick(3);
			chk({o_phase, o_cnt_run, seen_clr}, {2'd0, 2'b11});
			idle();
			// mode 9: short pulse blanks rest of on-time A
			sel_a = 4'h9; wait_phase(2'd1); i_fault_a = 1; tick(1); i_fault_a = 0; tick(3);
			chk({o_phase, o_pwm_out_a, o_cnt_run}, {2'd1, 2'b01});
			idle();
			// mode 10: off while high and after release in on-time
			sel_a = 4'hA; wait_phase(2'd0); wait_phase(2'd1); i_fault_a = 1; tick(4);
			chk({o_phase, o_pwm_out_a}, {2'd1, 1'b0});
			i_fault_a = 0; tick(4);
			chk({o_phase, o_pwm_out_a, o_cnt_run}, {2'd1, 2'b01});
			idle();
			// mode 3 on A: opposite half repeats while high, normal after
			sel_a = 4'h3; wait_phase(2'd0); wait_phase(2'd1); i_fault_a = 1; tick(4);
			chk({o_phase, o_pwm_out_a}, {2'd2, 1'b0});
			wait_phase(2'd3); while (o_phase === 2'd3) tick(1);
			chk(o_phase, 2'd2);
			i_fault_a = 0; wait_phase(2'd3); while (o_phase === 2'd3) tick(1);
			chk(o_phase, 2'd0);
			idle();
			// mode 5 on A: dead-times alternate while high
			sel_a = 4'h5; wait_phase(2'd1); i_fault_a = 1; tick(4);
			chk({o_phase, o_pwm_out_b, o_pwm_out_a}, {2'd2, 2'b00});
			while (o_phase === 2'd2) tick(1);
			chk(o_phase, 2'd0);
			i_fault_a = 0; while (o_phase === 2'd0) tick(1);
			chk({o_phase, o_pwm_out_b, o_pwm_out_a}, {2'd1, exp_out(2'd1)});
			idle();
			// mode 6 on B: jump to next dead-time and hold while high
			sel_b = 4'h6; wait_phase(2'd0); wait_phase(2'd1); i_fault_b = 1; tick(4);
			chk({o_phase, o_cnt_run, o_pwm_out_a}, {2'd2, 2'b00});
			tick(20); chk({o_phase, o_cnt_run}, {2'd2, 1'b0});
			i_fault_b = 0; tick(4); chk({o_phase, o_cnt_run}, {2'd2, 1'b1});
			idle();
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
